// file: dv/ccpu_pin_model.sv
// pin partner: sends a burst of rising pulses on the unit pin
// assumes go is a one-cycle request; pin idles low between bursts
`timescale 1ns/1ns
module ccpu_pin_model (
   input  wire logic       REF_CLK,
   input  wire logic       RST,
   input  wire logic       GO,
   input  wire logic [4:0] PULSES,
   output logic            PIN,
   output logic            BUSY
);
   logic [4:0] left_r;
   logic [3:0] ph_r;
   // eight cycles high, eight low per pulse; pad fed from outside only
   assign PIN = BUSY && (ph_r < 4'h8);
   always @(posedge REF_CLK) begin
      if (RST) begin
         BUSY   <= 1'b0;
         ph_r   <= 4'h0;
         left_r <= 5'h00;
      end else if (GO && !BUSY) begin
         BUSY   <= 1'b1;
         ph_r   <= 4'h0;
         left_r <= PULSES;
      end else if (BUSY) begin
         ph_r <= ph_r + 4'h1;
         if (ph_r == 4'hf) begin
            left_r <= left_r - 5'h01;
            if (left_r == 5'h01) BUSY <= 1'b0;
         end
      end
   end
endmodule

// file: dv/tb_top.sv
// bench for the capture/compare/pwm unit over apb
// assumes the second unit build and a pin model on the unit pin
`timescale 1ns/1ns
`include "ccpu_params.svh"
module tb_top
   import ccpu_pkg::*;
;
   typedef struct {logic [3:0] m; logic [4:0] n; logic [15:0] t; logic f;} ccpu_row_t;
   logic clk, rst, psel, pen, pwr, go, tick, per, adc, pin, busy, ready, err, rerr;
   logic [11:0] paddr;
   logic [31:0] pwd, prd, rdata;
   logic [15:0] t1;
   logic [7:0]  t2c;
   logic [4:0]  pn;
   logic po, pd, flg, t1r, sp, as;
   int miscompares, num_checks, n_sp, n_rst, n_adc, s0, r0, a0, cyc;
   ccpu_row_t rows[9] = '{'{4'h5,5'h01,16'h1234,1'b1}, '{4'h4,5'h01,16'habcd,1'b1},
      '{4'h6,5'h03,16'h0101,1'b0}, '{4'h6,5'h04,16'h0202,1'b1}, '{4'h7,5'h0f,16'h0303,1'b0},
      '{4'h7,5'h10,16'h0404,1'b1}, '{4'h1,5'h02,16'h0505,1'b0}, '{4'h3,5'h02,16'h0606,1'b0},
      '{4'h0,5'h02,16'h0707,1'b0}};
   ccpu_top #(.IS_SECOND(1'b1)) u_dut (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PSTRB(4'hf), .PRDATA(prd), .PREADY(ready),
      .PSLVERR(err), .UNIT_PIN_IN(pin), .TIMER_ONE_COUNT(t1), .TIMER_ONE_TICK(tick),
      .TIMER_TWO_COUNT(t2c), .TIMER_TWO_FINE(2'h0), .TIMER_TWO_PERIOD(per),
      .ADC_ENABLED(adc), .UNIT_PIN_OUT(po), .UNIT_PIN_DRIVE(pd), .UNIT_EVENT_FLAG(flg),
      .TIMER_ONE_RESET(t1r), .SPECIAL_TRIGGER(sp), .ADC_START(as));
   ccpu_pin_model u_pin (.REF_CLK(clk), .RST(rst), .GO(go), .PULSES(pn), .PIN(pin),
      .BUSY(busy));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc   <= cyc + 1;
      tick  <= (cyc % 4 == 0);
      n_sp  <= n_sp + (sp === 1'b1);
      n_rst <= n_rst + (t1r === 1'b1);
      n_adc <= n_adc + (as === 1'b1);
   end
   task tally_and_finish;
      if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel  <= 1'b1;
      pwr   <= w;
      paddr <= a;
      pwd   <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("pready", 0, 1);
         tally_and_finish();
      end
      rdata = prd;
      rerr  = err;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task pulse(input logic [4:0] n);
      int k;
      @(posedge clk);
      go <= 1'b1;
      pn <= n;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      for (k = 0; k < 600 && busy !== 1'b0; k++) @(posedge clk);
      if (k >= 600) begin
         chk("pin busy", 0, 1);
         tally_and_finish();
      end
      repeat (12) @(posedge clk);
   endtask
   task hit(input int n);
      t1 <= 16'h0050;
      repeat (n) @(posedge clk);
      t1 <= 16'h0000;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      {psel, pen, pwr, go, per, adc, miscompares, num_checks} = 0;
      {paddr, pwd, t1, t2c, pn} = 0;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      chk("outs", {po, pd, flg, t1r, sp, as}, 0);
      rd(`CCPU_OFS_CONTROL);
      chk("ctrl rst", rdata, `CCPU_CTRL_RST);
      wr(`CCPU_OFS_CONTROL, 32'hff);
      rd(`CCPU_OFS_CONTROL);
      chk("ctrl mask", rdata, 32'h3f);
      rd(12'h010);
      chk("unmapped err", rerr, 1);
      chk("unmapped data", rdata, 0);
      foreach (rows[i]) begin
         wr(`CCPU_OFS_CONTROL, 0);
         wr(`CCPU_OFS_VALUE, 0);
         wr(`CCPU_OFS_CONTROL, rows[i].m);
         wr(`CCPU_OFS_STATUS, 0);
         t1 <= rows[i].t;
         pulse(rows[i].n);
         rd(`CCPU_OFS_STATUS);
         chk("flag", {pd, rdata[0]}, rows[i].f);
         rd(`CCPU_OFS_VALUE);
         chk("value", rdata[15:0], rows[i].f ? rows[i].t : 16'h0);
      end
      wr(`CCPU_OFS_CONTROL, 5);
      t1 <= 16'h1111;
      pulse(1);
      t1 <= 16'h2222;
      pulse(1);
      repeat (50) @(posedge clk);
      rd(`CCPU_OFS_VALUE);
      chk("overwrite", rdata, 32'h2222);
      rd(`CCPU_OFS_STATUS);
      chk("sticky", rdata[0], 1);
      wr(`CCPU_OFS_STATUS, 0);
      @(posedge clk);
      chk("cleared", flg, 0);
      wr(`CCPU_OFS_CONTROL, 7);
      pulse(3);
      wr(`CCPU_OFS_CONTROL, 6);
      pulse(1);
      chk("prescale kept", flg, 1);
      wr(`CCPU_OFS_STATUS, 0);
      pulse(2);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      wr(`CCPU_OFS_CONTROL, 6);
      pulse(2);
      chk("reset prescale", flg, 0);
      pulse(2);
      chk("fourth edge", flg, 1);
      wr(`CCPU_OFS_CONTROL, 0);
      wr(`CCPU_OFS_STATUS, 0);
      t1 <= 16'h0000;
      wr(`CCPU_OFS_VALUE, 32'h50);
      wr(`CCPU_OFS_CONTROL, 8);
      hit(1);
      chk("set out", {po, pd, flg}, 3'h7);
      wr(`CCPU_OFS_CONTROL, 9);
      hit(1);
      chk("clr out", {po, pd}, 2'h1);
      wr(`CCPU_OFS_CONTROL, 0);
      wr(`CCPU_OFS_CONTROL, 2);
      hit(1);
      chk("toggle hi", po, 1);
      hit(1);
      chk("toggle lo", po, 0);
      wr(`CCPU_OFS_CONTROL, 0);
      wr(`CCPU_OFS_STATUS, 0);
      wr(`CCPU_OFS_CONTROL, 32'h0a);
      hit(1);
      chk("soft flag", {pd, flg}, 2'h1);
      adc <= 1'b1;
      {s0, r0, a0} = {n_sp, n_rst, n_adc};
      wr(`CCPU_OFS_CONTROL, 32'h0b);
      hit(12);
      chk("special", {pd, n_sp > s0, n_rst > r0, n_adc > a0}, 4'h7);
      adc <= 1'b0;
      a0 = n_adc;
      hit(12);
      chk("no adc", n_adc > a0, 0);
      wr(`CCPU_OFS_CONTROL, 0);
      wr(`CCPU_OFS_VALUE, 32'h40);
      wr(`CCPU_OFS_CONTROL, 32'h2c);
      @(posedge clk);
      per <= 1'b1;
      @(posedge clk);
      per <= 1'b0;
      repeat (4) @(posedge clk);
      chk("pwm high", {po, pd}, 2'h3);
      rd(`CCPU_OFS_PWM);
      chk("duty", rdata, 32'h102);
      t2c <= 8'h41;
      repeat (4) @(posedge clk);
      chk("pwm low", po, 0);
      tally_and_finish();
   end
endmodule

// file: src/ccpu_params.svh
// constants for the capture/compare/pwm unit
// assumes one 32-bit apb slave, word aligned registers
`ifndef CCPU_PARAMS_SVH
`define CCPU_PARAMS_SVH
`define CCPU_OFS_CONTROL   12'h000
`define CCPU_OFS_VALUE     12'h004
`define CCPU_OFS_STATUS    12'h008
`define CCPU_OFS_PWM       12'h00c
`define CCPU_CTRL_RST      8'h00
`define CCPU_CTRL_MASK     8'h3f
`define CCPU_DUTY_LSB      4
`define CCPU_PRE_4         4'h3
`define CCPU_PRE_16        4'hf
`endif

// file: src/ccpu_pkg.sv
// types for the capture/compare/pwm unit
// assumes ccpu_params.svh is included by the user
package ccpu_pkg;
   typedef enum logic [1:0] {CCPU_OFF, CCPU_CAP, CCPU_CMP, CCPU_PWM} ccpu_class_t;
endpackage

// file: src/ccpu_sync.sv
// three-stage pin synchroniser
// assumes an asynchronous single-bit input
`timescale 1ns/1ns
module ccpu_sync (
   input  wire logic REF_CLK,
   input  wire logic RST,
   input  wire logic PIN_IN,
   output logic      PIN_LEVEL
);
   logic [2:0] stage_r;
   logic       level_r;
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         stage_r <= 3'h0;
         level_r <= 1'b0;
      end else begin
         stage_r <= {stage_r[1:0], PIN_IN};
         if (stage_r[2] == stage_r[1]) begin
            level_r <= stage_r[1];
         end
      end
   end
   assign PIN_LEVEL = level_r;
endmodule

// file: src/ccpu_top.sv
// capture/compare/pwm unit with apb registers
// assumes external timer one/two counters; pin level fed back from pad
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "ccpu_params.svh"
module ccpu_top
   import ccpu_pkg::*;
#(
   parameter bit IS_SECOND = 1'b0
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        UNIT_PIN_IN,
   input  wire logic [15:0] TIMER_ONE_COUNT,
   input  wire logic        TIMER_ONE_TICK,
   input  wire logic [7:0]  TIMER_TWO_COUNT,
   input  wire logic [1:0]  TIMER_TWO_FINE,
   input  wire logic        TIMER_TWO_PERIOD,
   input  wire logic        ADC_ENABLED,
   output logic             UNIT_PIN_OUT,
   output logic             UNIT_PIN_DRIVE,
   output logic             UNIT_EVENT_FLAG,
   output logic             TIMER_ONE_RESET,
   output logic             SPECIAL_TRIGGER,
   output logic             ADC_START
);
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [15:0] value;
      logic        flag;
      logic        pin_prev;
      logic [3:0]  pre;
      logic        cmp_out;
      logic        trig_pend;
      logic [9:0]  duty;
      logic        pwm_out;
      logic        pin_out;
      logic        pin_drive;
      logic        t1_rst;
      logic        trig;
      logic        adc;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
   } ccpu_state_t;

   ccpu_state_t st_r;
   ccpu_state_t st_nxt;
   logic        pin_level;

   ccpu_sync u_sync (
      .REF_CLK   (REF_CLK),
      .RST       (RST),
      .PIN_IN    (UNIT_PIN_IN),
      .PIN_LEVEL (pin_level)
   );

   function automatic ccpu_class_t mode_class(input logic [3:0] m);
      if (m[3:2] == 2'b11) begin
         mode_class = CCPU_PWM;
      end else if (m[3:2] == 2'b01) begin
         mode_class = CCPU_CAP;
      end else if (m == 4'h2 || m[3:2] == 2'b10) begin
         mode_class = CCPU_CMP;
      end else begin
         mode_class = CCPU_OFF;
      end
   endfunction

   logic [3:0]  mode;
   ccpu_class_t cls;
   logic        rise;
   logic        fall;
   logic        cap_evt;
   logic        match;
   logic        wr;
   logic        rd_setup;
   logic        flag_set;
   assign mode  = st_r.ctrl[3:0];
   assign cls   = mode_class(mode);
   // edges from synchronised pad level, drive ignored
   assign rise  = pin_level & ~st_r.pin_prev;
   assign fall  = ~pin_level & st_r.pin_prev;
   assign match = (cls == CCPU_CMP) && (st_r.value == TIMER_ONE_COUNT);
   assign wr    = PSEL & PENABLE & PWRITE & st_r.ready;
   assign rd_setup = PSEL & ~PENABLE;

   always_comb begin
      st_nxt = st_r;
      st_nxt.pin_prev = pin_level;
      cap_evt = 1'b0;
      flag_set = 1'b0;
      st_nxt.t1_rst = 1'b0;
      st_nxt.trig = 1'b0;
      st_nxt.adc = 1'b0;
      // capture qualification, counter kept across prescale changes
      if (cls == CCPU_CAP) begin
         case (mode[1:0])
            2'b00: cap_evt = fall;
            2'b01: cap_evt = rise;
            2'b10: begin
               if (rise) begin
                  cap_evt = (st_r.pre[1:0] == 2'(`CCPU_PRE_4));
                  st_nxt.pre = st_r.pre + 4'h1;
               end
            end
            default: begin
               if (rise) begin
                  cap_evt = (st_r.pre == `CCPU_PRE_16);
                  st_nxt.pre = st_r.pre + 4'h1;
               end
            end
         endcase
      end else begin
         st_nxt.pre = 4'h0;
      end
      if (cap_evt) begin
         st_nxt.value = TIMER_ONE_COUNT;
         flag_set = 1'b1;
      end
      // compare actions
      if (match) begin
         flag_set = 1'b1;
         case (mode)
            4'h2: st_nxt.cmp_out = ~st_r.cmp_out;
            4'h8: st_nxt.cmp_out = 1'b1;
            4'h9: st_nxt.cmp_out = 1'b0;
            4'hb: begin
               st_nxt.trig = 1'b1;
               st_nxt.trig_pend = 1'b1;
               st_nxt.adc = IS_SECOND & ADC_ENABLED;
            end
            default: st_nxt.cmp_out = st_r.cmp_out;
         endcase
      end
      // timer reset waits for the next timer tick, cancelled if match lost
      if (st_r.trig_pend) begin
         if (!(mode == 4'hb && st_r.value == TIMER_ONE_COUNT)) begin
            st_nxt.trig_pend = 1'b0;
         end else if (TIMER_ONE_TICK) begin
            st_nxt.t1_rst = 1'b1;
            st_nxt.trig_pend = 1'b0;
         end
      end
      // pwm on timer two, duty latched at period event
      if (cls == CCPU_PWM) begin
         if (TIMER_TWO_PERIOD) begin
            st_nxt.duty = {st_r.value[7:0], st_r.ctrl[`CCPU_DUTY_LSB+1:`CCPU_DUTY_LSB]};
            st_nxt.pwm_out = 1'b1;
         end else if ({TIMER_TWO_COUNT, TIMER_TWO_FINE} >= st_r.duty) begin
            st_nxt.pwm_out = 1'b0;
         end
      end else begin
         st_nxt.pwm_out = 1'b0;
      end
      // pin ownership per mode
      st_nxt.pin_drive = (cls == CCPU_PWM) || (cls == CCPU_CMP && mode != 4'ha && mode != 4'hb);
      st_nxt.pin_out = (cls == CCPU_PWM) ? st_nxt.pwm_out : st_nxt.cmp_out;
      // apb slave, one wait state per transfer
      st_nxt.ready = 1'b0;
      st_nxt.slverr = 1'b0;
      if (PSEL & PENABLE & ~st_r.ready) begin
         st_nxt.ready = 1'b1;
         st_nxt.slverr = ~(PADDR == `CCPU_OFS_CONTROL || PADDR == `CCPU_OFS_VALUE ||
                           PADDR == `CCPU_OFS_STATUS || PADDR == `CCPU_OFS_PWM);
         case (PADDR)
            `CCPU_OFS_CONTROL: st_nxt.rdata = {24'h0, st_r.ctrl & `CCPU_CTRL_MASK};
            `CCPU_OFS_VALUE:   st_nxt.rdata = {16'h0, st_r.value};
            `CCPU_OFS_STATUS:  st_nxt.rdata = {31'h0, st_r.flag};
            `CCPU_OFS_PWM:     st_nxt.rdata = {22'h0, st_r.duty};
            default:           st_nxt.rdata = 32'h0;
         endcase
      end
      if (wr && PADDR == `CCPU_OFS_CONTROL && PSTRB[0]) begin
         st_nxt.ctrl = PWDATA[7:0] & `CCPU_CTRL_MASK;
         if (PWDATA[3:0] == 4'h0) begin
            st_nxt.cmp_out = 1'b0;
            st_nxt.trig_pend = 1'b0;
            st_nxt.pre = 4'h0;
         end
      end
      if (wr && PADDR == `CCPU_OFS_VALUE) begin
         if (PSTRB[0]) begin
            st_nxt.value[7:0] = PWDATA[7:0];
         end
         if (PSTRB[1]) begin
            st_nxt.value[15:8] = PWDATA[15:8];
         end
      end
      if (wr && PADDR == `CCPU_OFS_STATUS && PSTRB[0] && !PWDATA[0]) begin
         st_nxt.flag = 1'b0;
      end
      if (flag_set) begin
         st_nxt.flag = 1'b1; // set beats clear
      end
      if (rd_setup) begin
         st_nxt.rdata = st_r.rdata;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign PRDATA          = st_r.rdata;
   assign PREADY          = st_r.ready;
   assign PSLVERR         = st_r.slverr;
   assign UNIT_PIN_OUT    = st_r.pin_out;
   assign UNIT_PIN_DRIVE  = st_r.pin_drive;
   assign UNIT_EVENT_FLAG = st_r.flag;
   assign TIMER_ONE_RESET = st_r.t1_rst;
   assign SPECIAL_TRIGGER = st_r.trig;
   assign ADC_START       = st_r.adc;

   chk_flag_sticky: assert property (@(posedge REF_CLK) disable iff (RST)
      st_r.flag && !(wr && PADDR == `CCPU_OFS_STATUS) |=> st_r.flag)
      else $error("flag dropped without write");
   chk_capture_value: assert property (@(posedge REF_CLK) disable iff (RST)
      cap_evt |=> st_r.value == $past(TIMER_ONE_COUNT) && st_r.flag)
      else $error("capture value wrong");
   chk_prescale_clear: assert property (@(posedge REF_CLK) disable iff (RST)
      cls != CCPU_CAP |=> st_r.pre == 4'h0)
      else $error("prescaler not cleared");
   chk_reserved_idle: assert property (@(posedge REF_CLK) disable iff (RST)
      (mode == 4'h1 || mode == 4'h3 || mode == 4'h0) |=> !$past(flag_set) && !st_r.pin_drive)
      else $error("reserved mode acted");
   chk_rise_capture: assert property (@(posedge REF_CLK) disable iff (RST)
      mode == 4'h5 && rise |-> cap_evt)
      else $error("rising capture missed");
   chk_toggle_match: assert property (@(posedge REF_CLK) disable iff (RST)
      match && mode == 4'h2 && !wr |=> st_r.cmp_out != $past(st_r.cmp_out))
      else $error("toggle failed");
   chk_set_match: assert property (@(posedge REF_CLK) disable iff (RST)
      match && mode == 4'h8 && !wr |=> st_r.cmp_out && st_r.flag)
      else $error("set on match failed");
   chk_special_trig: assert property (@(posedge REF_CLK) disable iff (RST)
      match && mode == 4'hb |=> st_r.trig && st_r.adc == (IS_SECOND & $past(ADC_ENABLED)))
      else $error("special trigger wrong");
   chk_soft_pin: assert property (@(posedge REF_CLK) disable iff (RST)
      mode == 4'ha && !wr |=> !st_r.pin_drive)
      else $error("pin driven in flag-only mode");
   chk_ctrl_upper: assert property (@(posedge REF_CLK) disable iff (RST)
      st_r.ctrl[7:6] == 2'b00)
      else $error("upper control bits set");
endmodule
